// [pcc_pkg.sv]
// Shared constants and types for the projector control command port.
package pcc_pkg;

	// ========================================================
	// Bus addresses and command sub-addresses.
	localparam logic [7:0] ADDR_WRITE = 8'h34;
	localparam logic [7:0] ADDR_READ  = 8'h35;
	localparam logic [7:0] SUB_STATUS = 8'h00;
	localparam logic [7:0] SUB_MODE   = 8'h01;
	localparam logic [7:0] SUB_INDEX  = 8'h03;
	localparam logic [7:0] SUB_FINE   = 8'h04;
	localparam logic [7:0] SUB_SPEED  = 8'h05;
	localparam logic [7:0] SUB_SPIN   = 8'h06;
	localparam logic [7:0] SUB_COAST  = 8'h07;
	localparam logic [7:0] SUB_DEBUG  = 8'h08;
	localparam logic [7:0] SUB_STATE  = 8'h09;
	localparam logic [7:0] SUB_READ   = 8'h15;

	// ========================================================
	// Parameter byte counts.
	localparam logic [1:0] LEN_NONE  = 2'h0;
	localparam logic [1:0] LEN_ONE   = 2'h1;
	localparam logic [1:0] LEN_TWO   = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

	// ========================================================
	// Field positions and legal ranges.
	localparam int         FINE_SEL_BIT    = 23;
	localparam int         FINE_DLY_LSB    = 8;
	localparam int         SPEED_SEL_BIT   = 15;
	localparam int         STATE_DEBUG_BIT = 16;
	localparam int         STATE_COAST_BIT = 8;
	localparam int         STATE_SPIN_BIT  = 0;
	localparam int         STAT_READY_BIT  = 0;
	localparam int         STAT_ERR_BIT    = 1;
	localparam logic [9:0] DLY_MAX         = 10'h02CF;
	localparam logic [3:0] FRAC_MAX        = 4'h9;
	localparam logic [9:0] SPEED_MIN       = 10'h0078;
	localparam logic [9:0] SPEED_MAX       = 10'h030C;

	// ========================================================
	// Display modes.
	localparam logic [3:0] MODE_NORMAL  = 4'h0;
	localparam logic [3:0] MODE_FREEZE  = 4'h6;
	localparam logic [3:0] MODE_STANDBY = 4'h7;
	localparam logic [3:0] MODE_INVALID = 4'h8;

	// ========================================================
	// Reset values.
	localparam logic [7:0] NORMAL_STATUS = 8'h00;
	localparam logic [3:0] MODE_RST      = MODE_NORMAL;
	localparam logic [9:0] DLY_RST       = 10'h0000;
	localparam logic [3:0] FRAC_RST      = 4'h0;
	localparam logic [9:0] SPEED_RST     = 10'h0000;

	// ========================================================
	// Timing.
	localparam int CLK_HZ           = 32'h02FA_F080;
	localparam int CLK_PERIOD_NS    = 32'h0000_0014;
	localparam int EXEC_TIME_NS     = 32'h0000_00C8;
	localparam int EXEC_CYC         =
		(EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SPIN_OBSERVE_MS  = 32'h0000_03E8;
	localparam int SPIN_OBSERVE_CYC = CLK_HZ / 1000 * SPIN_OBSERVE_MS;
	localparam int TENTHS_PER_TURN  = 32'h0000_0E10;
	localparam int TENTHS_PER_HALF  = 32'h0000_0005;

	// Transfer states of the command port.
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_ADDR  = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_READ  = 4'b1000
	} pcc_state_t;

endpackage

// [pcc_wheel_if.sv]
// Signals between the command decoder and the wheel timing logic.
`timescale 1ns/1ps
interface pcc_wheel_if;
	logic       observe_start;
	logic       observe_busy;
	logic       spinning;
	logic       index_level;
	logic [9:0] dly_half;
	logic [3:0] dly_tenths;

	modport ctrl (
		output observe_start,
		output index_level,
		output dly_half,
		output dly_tenths,
		input  observe_busy,
		input  spinning
	);
	modport wheel (
		input  observe_start,
		input  index_level,
		input  dly_half,
		input  dly_tenths,
		output observe_busy,
		output spinning
	);
endinterface

// [pcc_pin_sync.sv]
// Three-stage synchronisers with agreement filter for external pins.
`timescale 1ns/1ps
module pcc_pin_sync #(
	parameter int W = 5
)(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);

	// ========================================================
	// One chain per pin; the level moves only when stages two and three
	// agree, so a single metastable sample never reaches the decoder.
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic lvl_r;
			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					s1_r  <= 1'b0;
					s2_r  <= 1'b0;
					s3_r  <= 1'b0;
					lvl_r <= 1'b0;
				end
				else
				begin
					s1_r <= pin_in[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r)
						lvl_r <= s3_r;
				end
			end
			assign level_out[i] = lvl_r;
		end
	endgenerate

endmodule

// [pcc_wheel_timing.sv]
// Wheel period measurement, index delay timing and spin observation.
`timescale 1ns/1ps
module pcc_wheel_timing #(
	parameter int OBSERVE_CYCLES = pcc_pkg::SPIN_OBSERVE_CYC,
	parameter int PERIOD_W       = 24
)(
	input  wire logic  clk,
	input  wire logic  rst,
	pcc_wheel_if.wheel wif,
	output logic       seq_start_out
);
	localparam int OBS_W = $clog2(OBSERVE_CYCLES + 1);
	localparam int TEN_W = 12;
	localparam int PRD_W = PERIOD_W + TEN_W;

	logic                index_d_r;
	logic                index_edge;
	logic [PERIOD_W-1:0] run_cnt_r;
	logic [PERIOD_W-1:0] period_r;
	logic [PERIOD_W-1:0] delay_r;
	logic [PERIOD_W-1:0] dly_cnt_r;
	logic                armed_r;
	logic [OBS_W-1:0]    obs_cnt_r;
	logic                seen_r;
	logic                spin_r;
	logic [TEN_W-1:0]    angle_tenths;
	logic [PRD_W-1:0]    product;
	logic [PRD_W-1:0]    quotient;

	// ========================================================
	// Angle in tenths of a degree scaled by the measured revolution time.
	assign index_edge   = wif.index_level & ~index_d_r;
	assign angle_tenths = TEN_W'(wif.dly_half) *
		TEN_W'(pcc_pkg::TENTHS_PER_HALF) + TEN_W'(wif.dly_tenths);
	assign product  = PRD_W'(period_r) * PRD_W'(angle_tenths);
	assign quotient = product / PRD_W'(pcc_pkg::TENTHS_PER_TURN);
	assign wif.observe_busy = (obs_cnt_r != '0);
	assign wif.spinning     = spin_r;

	// Period counter saturates so a stopped wheel never wraps to a short one.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			index_d_r <= 1'b0;
			run_cnt_r <= '0;
			period_r  <= '0;
			delay_r   <= '0;
		end
		else
		begin
			index_d_r <= wif.index_level;
			delay_r   <= quotient[PERIOD_W-1:0];
			if (index_edge)
			begin
				period_r  <= run_cnt_r;
				run_cnt_r <= '0;
			end
			else if (run_cnt_r != '1)
				run_cnt_r <= run_cnt_r + 1'b1;
		end
	end

	// Sequence start fires the programmed delay after each index edge.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dly_cnt_r     <= '0;
			armed_r       <= 1'b0;
			seq_start_out <= 1'b0;
		end
		else
		begin
			seq_start_out <= armed_r & (dly_cnt_r == '0) & ~index_edge;
			if (index_edge)
			begin
				dly_cnt_r <= delay_r;
				armed_r   <= 1'b1;
			end
			else if (armed_r && dly_cnt_r == '0)
				armed_r <= 1'b0;
			else if (armed_r)
				dly_cnt_r <= dly_cnt_r - 1'b1;
		end
	end

	// Spin query watches the index for the whole window, then reports.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			obs_cnt_r <= '0;
			seen_r    <= 1'b0;
			spin_r    <= 1'b0;
		end
		else if (wif.observe_start)
		begin
			obs_cnt_r <= OBS_W'(OBSERVE_CYCLES);
			seen_r    <= 1'b0;
		end
		else if (obs_cnt_r != '0)
		begin
			obs_cnt_r <= obs_cnt_r - 1'b1;
			if (index_edge)
				seen_r <= 1'b1;
			if (obs_cnt_r == OBS_W'(1))
				spin_r <= seen_r | index_edge;
		end
	end

endmodule

// [pcc_command_port.sv]
// Control command interpreter of the display controller.
`timescale 1ns/1ps
module pcc_command_port #(
	parameter int OBSERVE_CYCLES = pcc_pkg::SPIN_OBSERVE_CYC,
	parameter int EXEC_CYCLES    = pcc_pkg::EXEC_CYC
)(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       power_sense_input,
	input  wire logic       power_good_input,
	input  wire logic       wheel_index_pin,
	input  wire logic       wheel_coast_pin,
	input  wire logic       wheel_debug_pin,
	input  wire logic       bus_start,
	input  wire logic       bus_stop,
	input  wire logic       bus_wr_valid,
	input  wire logic [7:0] bus_wr_byte,
	input  wire logic       bus_rd_req,
	output logic            bus_addr_ack,
	output logic            bus_addr_nak,
	output logic      [7:0] bus_rd_byte,
	output logic            controller_ready_out,
	output logic            display_reset_out,
	output logic      [3:0] display_mode_field,
	output logic            image_update_en_out,
	output logic            illumination_en_out,
	output logic            wheel_motor_en_out,
	output logic            mirror_power_en_out,
	output logic            mirror_park_out,
	output logic            seq_start_out,
	output logic      [9:0] wheel_speed_primary_out,
	output logic      [9:0] wheel_speed_secondary_out,
	output logic     [13:0] fine_delay_secondary_out
);
	localparam int EXEC_W = $clog2(EXEC_CYCLES + 1);

	logic [4:0]           pin_raw;
	logic [4:0]           pin_level;
	logic                 rst_int;
	logic                 busy;
	pcc_pkg::pcc_state_t  state_r;
	pcc_pkg::pcc_state_t  state_nxt;
	logic [7:0]           sub_r;
	logic                 sub_seen_r;
	logic [1:0]           cnt_r;
	logic [23:0]          par_r;
	logic [3:0]           mode_r;
	logic [9:0]           dly_pri_r;
	logic [3:0]           frac_pri_r;
	logic [9:0]           dly_sec_r;
	logic [3:0]           frac_sec_r;
	logic [9:0]           speed_pri_r;
	logic [9:0]           speed_sec_r;
	logic [7:0]           rd_sel_r;
	logic [2:0]           rd_idx_r;
	logic                 err_r;
	logic [EXEC_W-1:0]    exec_cnt_r;
	logic [1:0]           need_len;
	logic [1:0]           rd_dlen;
	logic                 frame_end;
	logic                 enough;
	logic                 par_ok;
	logic                 cmd_valid;
	logic                 cmd_bad;
	logic                 addr_byte;
	logic                 addr_ours;
	logic [23:0]          reply_data;
	logic [15:0]          status_word;
	logic [1:0]           byte_pos;
	logic [7:0]           rd_byte_nxt;

	pcc_wheel_if wif ();

	// ========================================================
	// Sub-address decoding, shared by the write and read paths.
	function automatic logic [1:0] write_len(input logic [7:0] sub);
		case (sub)
			pcc_pkg::SUB_MODE:  write_len = pcc_pkg::LEN_ONE;
			pcc_pkg::SUB_INDEX: write_len = pcc_pkg::LEN_TWO;
			pcc_pkg::SUB_FINE:  write_len = pcc_pkg::LEN_THREE;
			pcc_pkg::SUB_SPEED: write_len = pcc_pkg::LEN_TWO;
			pcc_pkg::SUB_READ:  write_len = pcc_pkg::LEN_ONE;
			default:            write_len = pcc_pkg::LEN_NONE;
		endcase
	endfunction

	function automatic logic [1:0] read_len(input logic [7:0] sub);
		case (sub)
			pcc_pkg::SUB_STATUS: read_len = pcc_pkg::LEN_ONE;
			pcc_pkg::SUB_MODE:   read_len = pcc_pkg::LEN_ONE;
			pcc_pkg::SUB_INDEX:  read_len = pcc_pkg::LEN_TWO;
			pcc_pkg::SUB_FINE:   read_len = pcc_pkg::LEN_THREE;
			pcc_pkg::SUB_SPEED:  read_len = pcc_pkg::LEN_TWO;
			pcc_pkg::SUB_SPIN:   read_len = pcc_pkg::LEN_ONE;
			pcc_pkg::SUB_COAST:  read_len = pcc_pkg::LEN_ONE;
			pcc_pkg::SUB_DEBUG:  read_len = pcc_pkg::LEN_ONE;
			pcc_pkg::SUB_STATE:  read_len = pcc_pkg::LEN_THREE;
			default:             read_len = pcc_pkg::LEN_NONE;
		endcase
	endfunction

	// ========================================================
	// Pin synchronisers and the power-derived internal reset.
	assign pin_raw = {wheel_debug_pin, wheel_coast_pin, wheel_index_pin,
		power_good_input, power_sense_input};

	pcc_pin_sync #(
		.W (5)
	) u_sync (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.pin_in    (pin_raw),
		.level_out (pin_level)
	);

	// Synchronised levels start low, so the block holds itself in reset
	// until both power pins have been seen high for two samples.
	assign rst_int = sys_rst | ~pin_level[0] | ~pin_level[1];

	// ========================================================
	// Wheel timing engine, steered by the primary wheel delay settings.
	assign wif.index_level   = pin_level[2];
	assign wif.dly_half      = dly_pri_r;
	assign wif.dly_tenths    = frac_pri_r;
	assign wif.observe_start = cmd_valid &&
		sub_r == pcc_pkg::SUB_READ &&
		par_r[7:0] == pcc_pkg::SUB_SPIN;

	pcc_wheel_timing #(
		.OBSERVE_CYCLES (OBSERVE_CYCLES)
	) u_wheel (
		.clk           (clk),
		.rst           (rst_int),
		.wif           (wif.wheel),
		.seq_start_out (seq_start_out)
	);

	// ========================================================
	// Command validation; reserved bits are never examined.
	assign busy      = (exec_cnt_r != '0) | wif.observe_busy;
	assign need_len  = write_len(sub_r);
	assign frame_end = (bus_stop | bus_start) &
		(state_r == pcc_pkg::ST_WRITE) & sub_seen_r;
	// Too few bytes drops the frame silently; it is not an error.
	assign enough    = (need_len != pcc_pkg::LEN_NONE) & (cnt_r >= need_len);
	assign par_ok    =
		(sub_r == pcc_pkg::SUB_MODE)  ?
			(par_r[3:0] <= pcc_pkg::MODE_INVALID) :
		(sub_r == pcc_pkg::SUB_INDEX) ?
			(par_r[9:0] <= pcc_pkg::DLY_MAX) :
		(sub_r == pcc_pkg::SUB_FINE)  ?
			(par_r[17:8] <= pcc_pkg::DLY_MAX &&
			par_r[3:0] <= pcc_pkg::FRAC_MAX) :
		(sub_r == pcc_pkg::SUB_SPEED) ?
			(par_r[9:0] >= pcc_pkg::SPEED_MIN &&
			par_r[9:0] <= pcc_pkg::SPEED_MAX) :
			(read_len(par_r[7:0]) != pcc_pkg::LEN_NONE);
	assign cmd_valid = frame_end & enough & par_ok;
	assign cmd_bad   = frame_end & enough & ~par_ok;

	// ========================================================
	// Address byte handling; a busy device refuses both addresses.
	assign addr_byte = bus_wr_valid & (state_r == pcc_pkg::ST_ADDR);
	assign addr_ours = (bus_wr_byte == pcc_pkg::ADDR_WRITE) |
		(bus_wr_byte == pcc_pkg::ADDR_READ);

	// Next transfer state; a start always wins, then a stop.
	always_comb
	begin
		state_nxt = state_r;
		if (bus_start)
			state_nxt = pcc_pkg::ST_ADDR;
		else if (bus_stop)
			state_nxt = pcc_pkg::ST_IDLE;
		else
		begin
			case (state_r)
				pcc_pkg::ST_ADDR:
					if (bus_wr_valid && busy)
						state_nxt = pcc_pkg::ST_IDLE;
					else if (bus_wr_valid &&
						bus_wr_byte == pcc_pkg::ADDR_WRITE)
						state_nxt = pcc_pkg::ST_WRITE;
					else if (bus_wr_valid &&
						bus_wr_byte == pcc_pkg::ADDR_READ)
						state_nxt = pcc_pkg::ST_READ;
					else if (bus_wr_valid)
						state_nxt = pcc_pkg::ST_IDLE;
				pcc_pkg::ST_IDLE,
				pcc_pkg::ST_WRITE,
				pcc_pkg::ST_READ:
					state_nxt = state_r;
				default:
					state_nxt = pcc_pkg::ST_IDLE;
			endcase
		end
	end

	// Transfer state and the one-cycle acknowledge answers.
	always_ff @(posedge clk)
	begin
		if (rst_int)
		begin
			state_r      <= pcc_pkg::ST_IDLE;
			bus_addr_ack <= 1'b0;
			bus_addr_nak <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			bus_addr_ack <= addr_byte & addr_ours & ~busy;
			bus_addr_nak <= addr_byte & addr_ours & busy;
		end
	end

	// ========================================================
	// Byte collection; bytes past the expected count are dropped.
	always_ff @(posedge clk)
	begin
		if (rst_int || bus_start)
		begin
			sub_r      <= 8'h00;
			sub_seen_r <= 1'b0;
			cnt_r      <= pcc_pkg::LEN_NONE;
			par_r      <= 24'h00_0000;
		end
		else if (bus_wr_valid && state_r == pcc_pkg::ST_WRITE)
		begin
			if (!sub_seen_r)
			begin
				sub_r      <= bus_wr_byte;
				sub_seen_r <= 1'b1;
			end
			else if (cnt_r < need_len)
			begin
				par_r <= {par_r[15:0], bus_wr_byte};
				cnt_r <= cnt_r + 2'h1;
			end
		end
	end

	// ========================================================
	// Execution of validated commands; values reset to defaults, so the
	// host has to program delay and speed again after every reset.
	always_ff @(posedge clk)
	begin
		if (rst_int)
		begin
			mode_r      <= pcc_pkg::MODE_RST;
			dly_pri_r   <= pcc_pkg::DLY_RST;
			frac_pri_r  <= pcc_pkg::FRAC_RST;
			dly_sec_r   <= pcc_pkg::DLY_RST;
			frac_sec_r  <= pcc_pkg::FRAC_RST;
			speed_pri_r <= pcc_pkg::SPEED_RST;
			speed_sec_r <= pcc_pkg::SPEED_RST;
			rd_sel_r    <= pcc_pkg::SUB_STATUS;
		end
		else if (cmd_valid)
		begin
			case (sub_r)
				pcc_pkg::SUB_MODE:
					mode_r <= par_r[3:0];
				pcc_pkg::SUB_INDEX:
				begin
					dly_pri_r  <= par_r[9:0];
					frac_pri_r <= pcc_pkg::FRAC_RST;
				end
				pcc_pkg::SUB_FINE:
					if (par_r[pcc_pkg::FINE_SEL_BIT])
					begin
						dly_sec_r  <= par_r[pcc_pkg::FINE_DLY_LSB +: 10];
						frac_sec_r <= par_r[3:0];
					end
					else
					begin
						dly_pri_r  <= par_r[pcc_pkg::FINE_DLY_LSB +: 10];
						frac_pri_r <= par_r[3:0];
					end
				pcc_pkg::SUB_SPEED:
					if (par_r[pcc_pkg::SPEED_SEL_BIT])
						speed_sec_r <= par_r[9:0];
					else
						speed_pri_r <= par_r[9:0];
				default:
					rd_sel_r <= par_r[7:0];
			endcase
		end
	end

	// Busy timer and error flag; reads leave it, so status can report it.
	always_ff @(posedge clk)
	begin
		if (rst_int)
		begin
			exec_cnt_r <= '0;
			err_r      <= 1'b0;
		end
		else
		begin
			if (cmd_valid && sub_r != pcc_pkg::SUB_READ)
				exec_cnt_r <= EXEC_W'(EXEC_CYCLES);
			else if (exec_cnt_r != '0)
				exec_cnt_r <= exec_cnt_r - 1'b1;
			if (cmd_bad)
				err_r <= 1'b1;
			else if (cmd_valid && sub_r != pcc_pkg::SUB_READ)
				err_r <= 1'b0;
		end
	end

	// ========================================================
	// Read reply: data bytes most significant first, then two status.
	always_comb
	begin
		reply_data = 24'h00_0000;
		case (rd_sel_r)
			pcc_pkg::SUB_STATUS:
				reply_data[7:0] = pcc_pkg::NORMAL_STATUS;
			pcc_pkg::SUB_MODE:
				reply_data[3:0] = mode_r;
			pcc_pkg::SUB_INDEX:
				reply_data[9:0] = dly_pri_r;
			pcc_pkg::SUB_FINE:
			begin
				reply_data[pcc_pkg::FINE_DLY_LSB +: 10] = dly_pri_r;
				reply_data[3:0] = frac_pri_r;
			end
			pcc_pkg::SUB_SPEED:
				reply_data[9:0] = speed_pri_r;
			pcc_pkg::SUB_SPIN:
				reply_data[0] = wif.spinning;
			pcc_pkg::SUB_COAST:
				reply_data[0] = pin_level[3];
			pcc_pkg::SUB_DEBUG:
				reply_data[0] = pin_level[4];
			pcc_pkg::SUB_STATE:
			begin
				reply_data[pcc_pkg::STATE_DEBUG_BIT] = pin_level[4];
				reply_data[pcc_pkg::STATE_COAST_BIT] = pin_level[3];
				reply_data[pcc_pkg::STATE_SPIN_BIT]  = wif.spinning;
			end
			default:
				reply_data = 24'h00_0000;
		endcase
	end

	// Ready bit drops whenever a command is executing.
	always_comb
	begin
		status_word = 16'h0000;
		status_word[pcc_pkg::STAT_READY_BIT] = ~busy;
		status_word[pcc_pkg::STAT_ERR_BIT]   = err_r;
	end

	assign rd_dlen     = read_len(rd_sel_r);
	assign byte_pos    = rd_dlen - 2'h1 - rd_idx_r[1:0];
	assign rd_byte_nxt =
		(rd_idx_r < {1'b0, rd_dlen}) ? reply_data[{byte_pos, 3'b000} +: 8] :
		(rd_idx_r == {1'b0, rd_dlen}) ? status_word[15:8] :
		(rd_idx_r == {1'b0, rd_dlen} + 3'h1) ? status_word[7:0] : 8'h00;

	// Reply bytes appear one cycle after each request.
	always_ff @(posedge clk)
	begin
		if (rst_int || bus_start)
		begin
			rd_idx_r    <= 3'h0;
			bus_rd_byte <= 8'h00;
		end
		else if (bus_rd_req && state_r == pcc_pkg::ST_READ)
		begin
			bus_rd_byte <= rd_byte_nxt;
			if (rd_idx_r != 3'h7)
				rd_idx_r <= rd_idx_r + 3'h1;
		end
	end

	// ========================================================
	// Display side effects of the selected mode.
	assign controller_ready_out = ~(busy | rst_int);

	// Outputs fall to the safe, dark state during reset.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			display_reset_out <= 1'b1;
		else
			display_reset_out <= rst_int;
	end

	always_ff @(posedge clk)
	begin
		if (rst_int)
		begin
			image_update_en_out <= 1'b0;
			illumination_en_out <= 1'b0;
			wheel_motor_en_out  <= 1'b0;
			mirror_power_en_out <= 1'b0;
			mirror_park_out     <= 1'b1;
		end
		else
		begin
			image_update_en_out <= mode_r != pcc_pkg::MODE_FREEZE &&
				mode_r != pcc_pkg::MODE_STANDBY;
			illumination_en_out <= mode_r != pcc_pkg::MODE_STANDBY;
			wheel_motor_en_out  <= mode_r != pcc_pkg::MODE_STANDBY;
			mirror_power_en_out <= mode_r != pcc_pkg::MODE_STANDBY;
			mirror_park_out     <= mode_r == pcc_pkg::MODE_STANDBY;
		end
	end

	assign display_mode_field        = mode_r;
	assign wheel_speed_primary_out   = speed_pri_r;
	assign wheel_speed_secondary_out = speed_sec_r;
	assign fine_delay_secondary_out  = {dly_sec_r, frac_sec_r};

endmodule

// [pcc_command_port_asserts.sv]
// Concurrent checks on the command port pins.
`timescale 1ns/1ps
// ==========
module pcc_command_port_asserts (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       power_good_input,
	input wire logic       bus_addr_ack,
	input wire logic       bus_addr_nak,
	input wire logic       controller_ready_out,
	input wire logic       display_reset_out,
	input wire logic [3:0] display_mode_field,
	input wire logic       image_update_en_out,
	input wire logic       illumination_en_out,
	input wire logic       mirror_park_out
);
	// One clock domain, so clocking and disable are set once.
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_RST: assert property (disable iff (1'b0) sys_rst [*2]
		|=> display_reset_out && mirror_park_out && !controller_ready_out)
		else $error("reset state wrong");
	AST_PWR: assert property (!power_good_input [*8]
		|-> display_reset_out) else $error("power drop missed");
	AST_BUSY: assert property ($fell(controller_ready_out)
		&& !display_reset_out |=> !controller_ready_out [*8])
		else $error("ready back too soon");
	AST_ACK: assert property (bus_addr_ack
		|-> $past(controller_ready_out)) else $error("ack while busy");
	AST_NAK: assert property (bus_addr_nak
		|-> $past(!controller_ready_out)) else $error("nak while idle");
	AST_ONE: assert property (!(bus_addr_ack && bus_addr_nak))
		else $error("ack and nak");
	AST_MODE: assert property (display_mode_field <= 4'h8)
		else $error("reserved mode");
	AST_FRZ: assert property ((display_mode_field == 4'h6) [*2]
		|-> !image_update_en_out) else $error("freeze updates");
	AST_STBY: assert property ((display_mode_field == 4'h7) [*2]
		|-> !illumination_en_out && mirror_park_out)
		else $error("standby lit");
	cover property (bus_addr_ack);
	cover property (bus_addr_nak);
	cover property (display_mode_field == 4'h7);
endmodule
bind pcc_command_port pcc_command_port_asserts pcc_command_port_asserts_i (
	.clk, .sys_rst, .power_good_input, .bus_addr_ack, .bus_addr_nak,
	.controller_ready_out, .display_reset_out, .display_mode_field,
	.image_update_en_out, .illumination_en_out, .mirror_park_out);

// [pcc_host_model.sv]
// Host controller model driving the byte transport.
`timescale 1ns/1ps
// ==========
module pcc_host_model (
	input  wire logic       clk,
	input  wire logic       bus_addr_ack,
	input  wire logic       bus_addr_nak,
	input  wire logic [7:0] bus_rd_byte,
	input  wire logic       controller_ready_out,
	output logic            bus_start,
	output logic            bus_stop,
	output logic            bus_wr_valid,
	output logic      [7:0] bus_wr_byte,
	output logic            bus_rd_req
);
	logic [1:0] ak;
	initial {bus_start, bus_stop, bus_wr_valid, bus_wr_byte, bus_rd_req} = 0;
	task tk;
		@(posedge clk) #1;
	endtask
	// Waits for ready, bounded, since a busy port refuses us.
	task hold(input int c);
		repeat (c) if (!controller_ready_out) tk;
	endtask
	// Valid stays up across bytes; released data shows its inverse.
	task snd(input logic [7:0] a, s, input int n, input logic [23:0] d);
		bus_start = 1;
		tk;
		bus_start = 0;
		bus_wr_valid = 1;
		bus_wr_byte = a;
		tk;
		ak = {bus_addr_ack, bus_addr_nak};
		bus_wr_byte = s;
		tk;
		for (int i = n - 1; i >= 0; i--)
		begin
			bus_wr_byte = d[8*i+:8];
			tk;
		end
		bus_wr_valid = 0;
		bus_wr_byte = ~bus_wr_byte;
	endtask
	// The stop ends the frame and commits the write.
	task wr(input logic [7:0] a, s, input int n, input logic [23:0] d);
		snd(a, s, n, d);
		bus_stop = 1;
		tk;
		bus_stop = 0;
	endtask
	// Read frame: data bytes then two status bytes, MSB first.
	task get(input int n, output logic [39:0] v);
		snd(8'h35, 8'h00, -1, 0);
		v = 0;
		repeat (n + 2)
		begin
			bus_rd_req = 1;
			tk;
			bus_rd_req = 0;
			tk;
			v = {v[31:0], bus_rd_byte};
		end
	endtask
endmodule

// [projector_control_command_port_test.sv]
// Self-checking testbench of the command port.
`timescale 1ns/1ps
// ==========
module projector_control_command_port_test;
	logic        clk = 0, sys_rst = 1, pwr = 1, psn = 1, idx = 0, spin = 0;
	logic        coast = 1, dbg = 0;
	logic        bus_start, bus_stop, bus_wr_valid, bus_rd_req;
	logic        bus_addr_ack, bus_addr_nak, controller_ready_out;
	logic        display_reset_out, image_update_en_out;
	logic        illumination_en_out, mirror_park_out, mot, mpw, seq;
	logic  [7:0] bus_wr_byte, bus_rd_byte;
	logic  [3:0] display_mode_field;
	logic  [9:0] spd_p, spd_s;
	logic [13:0] fine_s;
	logic [39:0] v;
	int          mismatches = 0, checks_done = 0, seqs = 0;
	wire   [7:0] dark = {illumination_en_out, mot, mpw, mirror_park_out,
		display_mode_field};
	pcc_command_port #(.OBSERVE_CYCLES(200)) pcc_command_port_i (
		.clk, .sys_rst, .power_sense_input(psn), .power_good_input(pwr),
		.wheel_index_pin(idx), .wheel_coast_pin(coast),
		.wheel_debug_pin(dbg), .bus_start, .bus_stop, .bus_wr_valid,
		.bus_wr_byte, .bus_rd_req, .bus_addr_ack, .bus_addr_nak,
		.bus_rd_byte, .controller_ready_out, .display_reset_out,
		.display_mode_field, .image_update_en_out, .illumination_en_out,
		.wheel_motor_en_out(mot), .mirror_power_en_out(mpw), .mirror_park_out,
		.seq_start_out(seq), .wheel_speed_primary_out(spd_p),
		.wheel_speed_secondary_out(spd_s), .fine_delay_secondary_out(fine_s));
	pcc_host_model pcc_host_model_i (.clk, .bus_addr_ack, .bus_rd_byte,
		.bus_addr_nak, .controller_ready_out, .bus_start, .bus_stop,
		.bus_wr_valid, .bus_wr_byte, .bus_rd_req);
	// Clock and a wheel index that turns only while spin is set.
	always #10 clk = ~clk;
	initial #11 forever #1000 idx = spin & ~idx;
	// Sequence starts are counted on the falling edge, where they are settled.
	always @(negedge clk) if (seq) seqs++;
	task chk(input logic [39:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Waiting for ready first is how a polite host avoids refusals.
	task w(input logic [7:0] s, input int n, input logic [23:0] d);
		pcc_host_model_i.hold(40);
		pcc_host_model_i.wr(8'h34, s, n, d);
	endtask
	task r(input logic [7:0] s, input int n);
		pcc_host_model_i.hold(40);
		pcc_host_model_i.snd(8'h34, 8'h15, 1, s);
		pcc_host_model_i.get(n, v);
	endtask
	// Watchdog, far beyond the several hundred cycles the tests need.
	initial
	begin
		#300000;
		mismatches++;
		wrap_up;
	end
	// Main sequence.
	initial
	begin
		repeat (2) @(posedge clk);
		#1 sys_rst = 0;
		r(8'h00, 1);
		chk(v, 40'h1);
		chk(pcc_host_model_i.ak, 2);
		w(8'h01, 1, 8'h07);
		chk(controller_ready_out, 0);
		pcc_host_model_i.wr(8'h34, 8'h01, 1, 8'h00);
		chk(pcc_host_model_i.ak, 1);
		chk(dark, 8'h17);
		for (int m = 0; m < 10; m++)
		begin
			w(8'h01, 1, m);
			chk(display_mode_field, m < 9 ? m : 8);
		end
		w(8'h01, 1, 8'hf6);
		r(8'h01, 1);
		chk({image_update_en_out, v}, 41'h60001);
		for (int k = 0; k < 2; k++)
		begin
			w(8'h03, 2, 10'h2cf + k);
			r(8'h03, 2);
			chk(v, 40'h02cf_0001 + 2 * k);
		end
		w(8'h04, 3, 24'h82_cf09);
		chk(fine_s, 14'h2cf9);
		r(8'h04, 3);
		chk(v, 40'h02_cf00_0001);
		w(8'h05, 2, 16'h830c);
		w(8'h05, 2, 16'h0077);
		w(8'h05, 2, 16'h0078);
		chk({spd_s, spd_p}, 20'hc_3078);
		r(8'h05, 2);
		chk(v, 40'h0078_0001);
		r(8'h07, 1);
		chk(v, 40'h1_0001);
		r(8'h08, 1);
		chk(v, 40'h1);
		spin = 1;
		dbg = 1;
		w(8'h15, 1, 8'h06);
		pcc_host_model_i.hold(400);
		pcc_host_model_i.get(1, v);
		chk(v, 40'h1_0001);
		chk(seqs != 0, 1);
		r(8'h09, 3);
		chk(v, 40'h01_0101_0001);
		pwr = 0;
		repeat (10) pcc_host_model_i.tk;
		chk({display_reset_out, display_mode_field, spd_s}, 15'h4000);
		pwr = 1;
		w(8'h05, 2, 16'h0078);
		chk(spd_p, 10'h078);
		psn = 0;
		repeat (10) pcc_host_model_i.tk;
		chk({display_reset_out, spd_p}, 11'h400);
		psn = 1;
		wrap_up;
	end
endmodule
